// >>> rtl/mlsit_defines.vh
// Shared constants for the link status, gap throttle and flow control block
`ifndef MLSIT_DEFINES_VH
`define MLSIT_DEFINES_VH
`define MLSIT_CLK_PERIOD_NS      10
`define MLSIT_TXCLK_100M_NS      80
`define MLSIT_TXCLK_10M_NS       800
`define MLSIT_TXCLK_1G_NS        8
`define MLSIT_GAP_100M_NS        960
`define MLSIT_GAP_10M_NS         9600
`define MLSIT_GAP_1G_NS          96
`define MLSIT_SLOT_NS            512
`define MLSIT_GAP_100M_CYC       ((`MLSIT_GAP_100M_NS + `MLSIT_CLK_PERIOD_NS - 1) / `MLSIT_CLK_PERIOD_NS)
`define MLSIT_GAP_10M_CYC        ((`MLSIT_GAP_10M_NS + `MLSIT_CLK_PERIOD_NS - 1) / `MLSIT_CLK_PERIOD_NS)
`define MLSIT_GAP_1G_CYC         ((`MLSIT_GAP_1G_NS + `MLSIT_CLK_PERIOD_NS - 1) / `MLSIT_CLK_PERIOD_NS)
`define MLSIT_SLOT_CYC           ((`MLSIT_SLOT_NS + `MLSIT_CLK_PERIOD_NS - 1) / `MLSIT_CLK_PERIOD_NS)
`define MLSIT_TXCLK_10M_CYC      ((`MLSIT_TXCLK_10M_NS + `MLSIT_CLK_PERIOD_NS - 1) / `MLSIT_CLK_PERIOD_NS)
`define MLSIT_TXCLK_1G_CYC       ((`MLSIT_TXCLK_1G_NS + `MLSIT_CLK_PERIOD_NS - 1) / `MLSIT_CLK_PERIOD_NS)
`define MLSIT_SPEED_10           2'h0
`define MLSIT_SPEED_100          2'h1
`define MLSIT_SPEED_1000         2'h2
`define MLSIT_WMARK_W            13
`define MLSIT_FIFO_W             8
`define MLSIT_FIFO_DEPTH         16
`define MLSIT_FIFO_AW            4
`endif

// >>> rtl/mlsit_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module mlsit_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             rst_i,
  // Write side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Read side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;
  reg [AW:0]      count;
  reg             have;
  wire            wr;
  wire            rd;
  wire            load;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign wr          = in_valid_i && in_ready_o;
  // Output register is refilled whenever empty or consumed
  assign load        = (count != {(AW+1){1'b0}}) && (!have || out_ready_i);
  assign rd          = load;
  assign out_valid_o = have;

  always @(posedge mclk_i)
  begin
    if (wr)
      mem[wptr] <= in_data_i;
  end

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wptr       <= {AW{1'b0}};
      rptr       <= {AW{1'b0}};
      count      <= {(AW+1){1'b0}};
      have       <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wr)
        wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
      if (rd)
      begin
        rptr       <= rptr + {{(AW-1){1'b0}}, 1'b1};
        out_data_o <= mem[rptr];
        have       <= 1'b1;
      end
      else if (out_ready_i)
        have <= 1'b0;
      if (wr && !rd)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (rd && !wr)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

// >>> rtl/mlsit_top.v
// Link status, adaptive gap throttle and flow control parameters of the MAC
// Summary of operation
// [R1] Serdes mode: lost signal marks link down and disables MAC, even when forced up.
// [R2] Lost signal restarts auto-negotiation and blocks its completion until cleared.
// [R3] Enabled link change pulse posted on every link up and link down.
// [R4] Internal PHY mode: MAC disabled whenever PHY link indication is low.
// [R5] Minimum back-to-back gap 960 ns at 100 Mb/s, 9.6 us at 10 Mb/s.
// [R6] Throttle holds back-to-back frames before handing them to CSMA/CD transmit.
// [R7] Throttle is 16-bit count of transmit clocks, 80 ns each at 100 Mb/s.
// [R8] Never start before standard minimum gap; smaller throttle values have no effect.
// [R9] No throttle after a receive nor on non back-to-back frames.
// [R10] Retransmissions after collisions keep normal timing, ignoring the throttle.
// [R11] Back-to-back gap is the larger of throttle and base gap, not the sum.
// [R12] Software should keep throttle at zero unless extra delay is wanted.
// [R13] Holds a programmable 6-byte multicast destination for flow control frames.
// [R14] Holds 13-bit high watermark compared against receive buffer fullness.
// [R15] Holds 13-bit low watermark signalling receive buffer emptiness.
// [R16] Holds 16-bit pause time value placed into each transmitted pause frame.
// [R17] Holds programmable 16-bit type value identifying flow control frames.
// [R18] Asymmetric mode may send flow control frames while ignoring received ones.
// [R19] Negotiation settles symmetric or asymmetric flow control per partner abilities.
// [R20] Pause time counted in slot times of 512 ns each; the slot is rounded up to 52 clocks (520 ns).
// [R21] Lost signal and internal link inputs synchronised before use.
`timescale 1ns/100ps
`include "mlsit_defines.vh"
module mlsit_top #(
  parameter DW = `MLSIT_FIFO_W,
  parameter FD = `MLSIT_FIFO_DEPTH,
  parameter FA = `MLSIT_FIFO_AW
) (
  // Clock and reset
  input  wire          mclk_i,
  input  wire          rst_i,
  // Mode and link inputs
  input  wire          ten_bit_iface_mode_i,
  input  wire          signal_lost_input_i,
  input  wire          phy_link_up_i,
  input  wire          force_link_up_i,
  input  wire          autoneg_enable_i,
  input  wire          autoneg_done_i,
  input  wire          link_change_irq_en_i,
  input  wire [1:0]    speed_i,
  // Link status outputs
  output reg           link_up_o,
  output wire          mac_enable_o,
  output reg           autoneg_restart_o,
  output wire          autoneg_allow_o,
  output reg           link_change_irq_o,
  // Gap configuration
  input  wire [15:0]   gap_throttle_reg_i,
  input  wire [9:0]    base_tx_gap_i,
  // Receive and transmit events
  input  wire          rx_end_i,
  input  wire          tx_end_i,
  input  wire          tx_collision_i,
  // Frame data stream from transmit DMA
  input  wire          tx_valid_i,
  output wire          tx_ready_o,
  input  wire [DW-1:0] tx_data_i,
  input  wire          tx_first_i,
  // Stream toward CSMA/CD transmit function
  output wire          mac_valid_o,
  input  wire          mac_ready_i,
  output wire [DW-1:0] mac_data_o,
  output wire          gap_hold_o,
  // Flow control parameters
  input  wire [47:0]   pause_dest_addr_i,
  input  wire [12:0]   rx_high_watermark_i,
  input  wire [12:0]   rx_low_watermark_i,
  input  wire [15:0]   pause_time_value_i,
  input  wire [15:0]   pause_frame_type_i,
  input  wire [12:0]   rx_fill_level_i,
  input  wire          local_pause_i,
  input  wire          local_asm_dir_i,
  input  wire          partner_pause_i,
  input  wire          partner_asm_dir_i,
  // Flow control outputs
  output reg  [47:0]   fc_dest_addr_o,
  output reg  [15:0]   fc_type_o,
  output reg  [15:0]   fc_pause_time_o,
  output reg           rx_above_high_o,
  output reg           rx_below_low_o,
  output reg           fc_tx_enable_o,
  output reg           fc_rx_enable_o,
  output reg  [31:0]   pause_quanta_cyc_o
);
  localparam [15:0] GAP100 = `MLSIT_GAP_100M_CYC;
  localparam [15:0] GAP10  = `MLSIT_GAP_10M_CYC;
  localparam [15:0] GAP1G  = `MLSIT_GAP_1G_CYC;
  localparam [15:0] TXC100 = `MLSIT_TXCLK_100M_NS / `MLSIT_CLK_PERIOD_NS;
  localparam [15:0] TXC10  = `MLSIT_TXCLK_10M_CYC;
  localparam [15:0] TXC1G  = `MLSIT_TXCLK_1G_CYC;
  localparam [9:0]  SLOT   = `MLSIT_SLOT_CYC;

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEND = 4'h2;
  localparam [3:0] ST_GAP  = 4'h4;
  localparam [3:0] ST_OPEN = 4'h8;

  // Three-stage synchronisers; only stages two and three are compared
  reg  [2:0] los_sync;
  reg  [2:0] phy_sync;
  reg        los_s;
  reg        phy_s;
  reg        link_now;
  reg        link_prev;

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      los_sync <= 3'h0;
      phy_sync <= 3'h0;
      los_s    <= 1'b0;
      phy_s    <= 1'b0;
    end
    else
    begin
      los_sync <= {los_sync[1:0], signal_lost_input_i}; // R21
      phy_sync <= {phy_sync[1:0], phy_link_up_i}; // R21
      if (los_sync[2] == los_sync[1])
        los_s <= los_sync[2]; // R21
      if (phy_sync[2] == phy_sync[1])
        phy_s <= phy_sync[2]; // R21
    end
  end

  always @*
  begin
    link_now = 1'b0;
    if (ten_bit_iface_mode_i)
    begin
      if (los_s)
        link_now = 1'b0; // R1
      else if (autoneg_enable_i)
        link_now = autoneg_done_i;
      else
        link_now = force_link_up_i;
    end
    else
      link_now = phy_s; // R4
  end

  assign mac_enable_o    = link_up_o; // R1 R4
  assign autoneg_allow_o = !(ten_bit_iface_mode_i && los_s); // R2

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link_up_o         <= 1'b0;
      link_prev         <= 1'b0;
      autoneg_restart_o <= 1'b0;
      link_change_irq_o <= 1'b0;
    end
    else
    begin
      link_up_o         <= link_now;
      link_prev         <= link_up_o;
      autoneg_restart_o <= ten_bit_iface_mode_i && autoneg_enable_i && los_s; // R2
      link_change_irq_o <= link_change_irq_en_i && (link_prev != link_up_o); // R3
    end
  end

  // Gap throttle: FIFO buffers the frame stream; the gate stalls its drain side
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [15:0] gap_cnt;
  reg  [15:0] gap_need;
  reg         after_rx;
  reg         retry;
  reg  [15:0] ieee_min;
  reg  [15:0] txclk_cyc;
  reg  [31:0] thr_cyc;
  reg  [15:0] thr_sat;
  reg  [15:0] base_cyc;
  reg  [31:0] base_prod;
  reg  [15:0] larger;
  wire        f_valid;
  wire        f_ready;
  wire [DW-1:0] f_data;

  mlsit_fifo #(
    .WIDTH (DW),
    .DEPTH (FD),
    .AW    (FA)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (tx_data_i),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  always @*
  begin
    case (speed_i)
      `MLSIT_SPEED_10:
      begin
        ieee_min  = GAP10; // R5
        txclk_cyc = TXC10;
      end
      `MLSIT_SPEED_100:
      begin
        ieee_min  = GAP100; // R5
        txclk_cyc = TXC100; // R7
      end
      default:
      begin
        ieee_min  = GAP1G; // R8
        txclk_cyc = TXC1G;
      end
    endcase
    thr_cyc  = {16'h0000, gap_throttle_reg_i} * {16'h0000, txclk_cyc}; // R7
    thr_sat  = (thr_cyc[31:16] != 16'h0000) ? 16'hffff : thr_cyc[15:0];
    // Base gap saturates too, a large value at 10 Mb/s would otherwise wrap short
    base_prod = {{22{1'b0}}, base_tx_gap_i} * {16'h0000, txclk_cyc};
    base_cyc = (base_prod[31:16] != 16'h0000) ? 16'hffff : base_prod[15:0];
    larger   = (thr_sat > base_cyc) ? thr_sat : base_cyc; // R11
    if (larger < ieee_min)
      larger = ieee_min; // R8
  end

  // Hold the stream only while a back-to-back gap is running
  assign f_ready     = mac_ready_i && (state != ST_GAP); // R6
  assign mac_valid_o = f_valid && (state != ST_GAP); // R6
  assign mac_data_o  = f_data;
  assign gap_hold_o  = (state == ST_GAP);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (f_valid && mac_ready_i)
          next_state = ST_SEND;
      ST_SEND:
        if (tx_end_i)
          next_state = ST_GAP;
      ST_GAP:
        if (retry || after_rx || (gap_cnt >= gap_need))
          next_state = ST_OPEN; // R9 R10
      ST_OPEN:
        if (f_valid && mac_ready_i)
          next_state = ST_SEND;
        else if (!f_valid)
          next_state = ST_IDLE; // R9
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state    <= ST_IDLE;
      gap_cnt  <= 16'h0000;
      gap_need <= 16'h0000;
      after_rx <= 1'b0;
      retry    <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_SEND && tx_end_i)
      begin
        // Counting from one makes the hold last exactly gap_need cycles
        gap_cnt  <= 16'h0001;
        gap_need <= larger; // R11
      end
      else if (gap_cnt != 16'hffff)
        gap_cnt <= gap_cnt + 16'h0001;
      // Set wins: a receive seen at the frame end still releases the gap
      if (rx_end_i)
        after_rx <= 1'b1; // R9
      else if (state == ST_OPEN || state == ST_IDLE)
        after_rx <= 1'b0;
      if (tx_collision_i)
        retry <= 1'b1; // R10
      else if (state == ST_OPEN)
        retry <= 1'b0;
    end
  end

  // Flow control parameters and negotiated direction
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fc_dest_addr_o     <= 48'h0;
      fc_type_o          <= 16'h0000;
      fc_pause_time_o    <= 16'h0000;
      rx_above_high_o    <= 1'b0;
      rx_below_low_o     <= 1'b0;
      fc_tx_enable_o     <= 1'b0;
      fc_rx_enable_o     <= 1'b0;
      pause_quanta_cyc_o <= 32'h0;
    end
    else
    begin
      fc_dest_addr_o     <= pause_dest_addr_i; // R13
      fc_type_o          <= pause_frame_type_i; // R17
      fc_pause_time_o    <= pause_time_value_i; // R16
      pause_quanta_cyc_o <= {16'h0000, pause_time_value_i} * {{22{1'b0}}, SLOT}; // R20
      rx_above_high_o    <= (rx_fill_level_i >= rx_high_watermark_i); // R14
      rx_below_low_o     <= (rx_fill_level_i <= rx_low_watermark_i); // R15
      if (local_pause_i && partner_pause_i)
      begin
        fc_tx_enable_o <= 1'b1; // R19
        fc_rx_enable_o <= 1'b1; // R19
      end
      else if (local_asm_dir_i && partner_asm_dir_i && !local_pause_i && partner_pause_i)
      begin
        fc_tx_enable_o <= 1'b1; // R18
        fc_rx_enable_o <= 1'b0; // R18
      end
      else if (local_asm_dir_i && partner_asm_dir_i && local_pause_i)
      begin
        fc_tx_enable_o <= 1'b0; // R19
        fc_rx_enable_o <= 1'b1; // R19
      end
      else
      begin
        fc_tx_enable_o <= 1'b0;
        fc_rx_enable_o <= 1'b0;
      end
    end
  end
endmodule

// >>> tb/mlsit_top_monitor.sv
// Concurrent checks on the ports of the link status and gap throttle block
`timescale 1ns/100ps
module mlsit_top_monitor (
  // Clock and reset
  input wire        mclk_i,
  input wire        rst_i,
  // Link side
  input wire        ten_bit_iface_mode_i,
  input wire        signal_lost_input_i,
  input wire        phy_link_up_i,
  input wire        autoneg_enable_i,
  input wire        link_change_irq_en_i,
  input wire        link_up_o,
  input wire        mac_enable_o,
  input wire        autoneg_restart_o,
  input wire        autoneg_allow_o,
  input wire        link_change_irq_o,
  // Gap side
  input wire [1:0]  speed_i,
  input wire [15:0] gap_throttle_reg_i,
  input wire [9:0]  base_tx_gap_i,
  input wire        rx_end_i,
  input wire        tx_end_i,
  input wire        tx_collision_i,
  input wire        mac_valid_o,
  input wire        gap_hold_o
);
  logic [31:0] tc, mn, thr, bs, need, gcnt;
  logic        brk;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  assign tc = speed_i == 2'h0 ? 32'h50 : speed_i == 2'h1 ? 32'h8 : 32'h1;
  assign mn = speed_i == 2'h0 ? 32'h3c0 : speed_i == 2'h1 ? 32'h60 : 32'ha;
  // Saturate so a huge throttle or base gap never wraps into a short gap
  assign thr = gap_throttle_reg_i * tc > 32'hffff ? 32'hffff : gap_throttle_reg_i * tc;
  assign bs = base_tx_gap_i * tc > 32'hffff ? 32'hffff : base_tx_gap_i * tc;
  assign need = thr > bs ? (thr > mn ? thr : mn) : (bs > mn ? bs : mn);
  always_ff @(posedge mclk_i or posedge rst_i)
    gcnt <= rst_i ? 32'h0 : gap_hold_o ? gcnt + 32'h1 : 32'h0;
  // A receive or collision cuts the gap short, so such gaps are not measured
  always_ff @(posedge mclk_i or posedge rst_i)
    brk <= rst_i ? 1'b0 : gap_hold_o && (brk || rx_end_i || tx_collision_i);
  a_mac_follow_link: assert property ((!ten_bit_iface_mode_i && phy_link_up_i) [*8] |-> mac_enable_o)
    else $error("mac not enabled while phy reports up");
  a_lost_link_down: assert property ((ten_bit_iface_mode_i && signal_lost_input_i) [*8] |-> !link_up_o)
    else $error("link up while signal lost");
  a_lost_restart: assert property ((ten_bit_iface_mode_i && autoneg_enable_i && signal_lost_input_i) [*8] |-> autoneg_restart_o)
    else $error("no negotiation restart while signal lost");
  a_lost_no_allow: assert property ((ten_bit_iface_mode_i && signal_lost_input_i) [*8] |-> !autoneg_allow_o)
    else $error("negotiation allowed while signal lost");
  a_phy_link_down: assert property ((!ten_bit_iface_mode_i && !phy_link_up_i) [*8] |-> !link_up_o)
    else $error("link up while phy reports down");
  a_irq_on_change: assert property ($changed(link_up_o) && link_change_irq_en_i |-> ##1 link_change_irq_o)
    else $error("missing link change pulse");
  a_irq_one_cycle: assert property (link_change_irq_o |=> !link_change_irq_o)
    else $error("link change pulse too long");
  a_gap_holds_tx: assert property (gap_hold_o |-> !mac_valid_o)
    else $error("data offered during gap");
  a_rx_cuts_gap: assert property (gap_hold_o && rx_end_i |-> ##2 !gap_hold_o)
    else $error("gap not released after receive");
  a_coll_cuts_gap: assert property (gap_hold_o && tx_collision_i |-> ##2 !gap_hold_o)
    else $error("gap not released after collision");
  a_gap_length: assert property ($fell(gap_hold_o) && !brk && !rx_end_i && !tx_collision_i |-> gcnt == need)
    else $error("gap length wrong");
endmodule

bind mlsit_top mlsit_top_monitor mon_u (.*);

// >>> tb/mlsit_sink.sv
// Model of the CSMA/CD transmit side that consumes the frame stream
`timescale 1ns/100ps
module mlsit_sink (
  // Clock and reset
  input  wire       mclk_i,
  input  wire       rst_i,
  // Stream from the block
  input  wire       valid_i,
  input  wire [7:0] data_i,
  output reg        ready_o,
  // Pacing from the bench
  input  wire       stall_i,
  input  wire       slow_i
);
  logic [7:0] got[$];
  // Slow pacing toggles ready so the block also meets a late answer
  always @(posedge mclk_i or posedge rst_i)
    ready_o <= rst_i ? 1'b0 : !stall_i && (!slow_i || !ready_o);
  always @(posedge mclk_i)
    if (!rst_i && valid_i && ready_o)
      got.push_back(data_i);
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the link status, gap throttle and flow control block
`timescale 1ns/100ps
module testbench;
  logic        mclk_i, rst_i, ten_bit_iface_mode_i, signal_lost_input_i, phy_link_up_i;
  logic        force_link_up_i, autoneg_enable_i, autoneg_done_i, link_change_irq_en_i;
  logic        link_up_o, mac_enable_o, autoneg_restart_o, autoneg_allow_o, link_change_irq_o;
  logic        rx_end_i, tx_end_i, tx_collision_i, tx_valid_i, tx_ready_o, tx_first_i;
  logic        mac_valid_o, mac_ready_i, gap_hold_o, local_pause_i, local_asm_dir_i;
  logic        partner_pause_i, partner_asm_dir_i, rx_above_high_o, rx_below_low_o;
  logic        fc_tx_enable_o, fc_rx_enable_o, stall, slow;
  logic [1:0]  speed_i;
  logic [7:0]  tx_data_i, mac_data_o;
  logic [9:0]  base_tx_gap_i;
  logic [12:0] rx_high_watermark_i, rx_low_watermark_i, rx_fill_level_i;
  logic [15:0] gap_throttle_reg_i, pause_time_value_i, pause_frame_type_i, fc_type_o, fc_pause_time_o;
  logic [31:0] pause_quanta_cyc_o;
  logic [47:0] pause_dest_addr_i, fc_dest_addr_o;
  logic [12:0] fl[4] = '{13'h0100, 13'h00ff, 13'h0040, 13'h0041};
  logic [1:0]  ex[4] = '{2'h2, 2'h0, 2'h1, 2'h0};
  int          fail_count = 0, num_checks = 0, irq_n = 0, i, n;

  mlsit_top dut_u (.*);
  mlsit_sink sink_u (.mclk_i(mclk_i), .rst_i(rst_i), .valid_i(mac_valid_o), .data_i(mac_data_o),
                     .ready_o(mac_ready_i), .stall_i(stall), .slow_i(slow));

  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task wt(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  task end_of_test;
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Leaves valid high so back-to-back calls never lower and raise it in one step
  task push(input logic [7:0] d);
    tx_data_i = d;
    tx_valid_i = 1'b1;
    for (n = 0; n < 100 && tx_ready_o !== 1'b1; n++)
      wt(1);
    wt(1);
  endtask

  task gap(input logic [1:0] sp, input logic [15:0] thr, input logic [9:0] bs, input int brk, exp);
    speed_i = sp;
    gap_throttle_reg_i = thr;
    base_tx_gap_i = bs;
    sink_u.got.delete();
    push(8'h5a);
    tx_valid_i = 1'b0;
    for (n = 0; n < 20 && sink_u.got.size() == 0; n++)
      wt(1);
    // Second frame is queued in the same cycle as the frame end, so the pair is back-to-back
    tx_end_i = 1'b1;
    tx_valid_i = 1'b1;
    tx_data_i = 8'ha5;
    wt(1);
    {tx_end_i, tx_valid_i} = 2'h0;
    for (n = 0; gap_hold_o === 1'b1 && n < 2000; n++)
    begin
      rx_end_i = brk == 1 && n == 4;
      tx_collision_i = brk == 2 && n == 4;
      wt(1);
    end
    {rx_end_i, tx_collision_i} = 2'h0;
    chk(brk ? 64'(n < 8) : 64'(n), 64'(exp));
    wt(6);
    chk(sink_u.got.size(), 2);
    tx_end_i = 1'b1;
    wt(1);
    tx_end_i = 1'b0;
    for (n = 0; gap_hold_o === 1'b1 && n < 2000; n++)
      wt(1);
    wt(2);
  endtask

  function logic [1:0] res(input logic [3:0] v);
    if (v[3] && v[1])
      return 2'h3;
    if (v == 4'h7)
      return 2'h2;
    if (v == 4'hd)
      return 2'h1;
    return 2'h0;
  endfunction

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
    if (link_change_irq_o === 1'b1)
      irq_n++;

  initial
  begin
    #600us;
    fail_count++;
    end_of_test;
  end

  initial
  begin
    {rst_i, ten_bit_iface_mode_i, force_link_up_i, phy_link_up_i, link_change_irq_en_i} = 5'h1f;
    {signal_lost_input_i, autoneg_enable_i, autoneg_done_i, rx_end_i, tx_end_i} = 5'h0;
    {tx_collision_i, tx_valid_i, tx_first_i, stall, slow, tx_data_i} = 13'h0;
    {local_pause_i, local_asm_dir_i, partner_pause_i, partner_asm_dir_i, speed_i} = 6'h2;
    {base_tx_gap_i, gap_throttle_reg_i, rx_fill_level_i} = 39'h0;
    {pause_dest_addr_i, pause_frame_type_i} = 64'h0180c2000001_8808;
    {pause_time_value_i, rx_high_watermark_i, rx_low_watermark_i} = {16'h0100, 13'h0100, 13'h0040};
    wt(3);
    rst_i = 1'b0;
    wt(10);
    chk({link_up_o, irq_n[3:0]}, 5'h11);
    signal_lost_input_i = 1'b1;
    wt(10);
    chk({link_up_o, mac_enable_o, irq_n[3:0]}, 6'h02);
    {autoneg_enable_i, autoneg_done_i} = 2'h3;
    wt(10);
    chk({autoneg_restart_o, autoneg_allow_o, link_up_o}, 3'h4);
    signal_lost_input_i = 1'b0;
    wt(10);
    chk({autoneg_restart_o, autoneg_allow_o, link_up_o, irq_n[3:0]}, 7'h33);
    {autoneg_enable_i, ten_bit_iface_mode_i} = 2'h0;
    wt(10);
    chk(link_up_o, 1);
    phy_link_up_i = 1'b0;
    wt(10);
    chk({mac_enable_o, irq_n[3:0]}, 5'h04);
    {link_change_irq_en_i, phy_link_up_i} = 2'h1;
    wt(10);
    chk({link_up_o, irq_n[3:0]}, 5'h14);
    link_change_irq_en_i = 1'b1;
    chk({fc_dest_addr_o, fc_type_o}, 64'h0180c2000001_8808);
    chk({fc_pause_time_o, pause_quanta_cyc_o}, 48'h0100_00003400);
    for (i = 0; i < 4; i++)
    begin
      rx_fill_level_i = fl[i];
      wt(2);
      chk({rx_above_high_o, rx_below_low_o}, ex[i]);
    end
    for (i = 0; i < 16; i++)
    begin
      {local_pause_i, local_asm_dir_i, partner_pause_i, partner_asm_dir_i} = i[3:0];
      wt(2);
      chk({fc_tx_enable_o, fc_rx_enable_o}, res(i[3:0]));
    end
    stall = 1'b1;
    wt(2);
    tx_valid_i = 1'b1;
    for (i = 0; i < 20 && tx_ready_o === 1'b1; i++)
    begin
      tx_data_i = i[7:0];
      wt(1);
    end
    tx_valid_i = 1'b0;
    // Sixteen words in memory plus one in the output register
    chk(i, 17);
    stall = 1'b0;
    wt(40);
    chk(sink_u.got.size(), 17);
    for (i = 0; i < 17; i++)
      chk(sink_u.got[i], i);
    tx_end_i = 1'b1;
    wt(1);
    tx_end_i = 1'b0;
    wt(20);
    gap(2'h1, 16'd10, 10'd0, 0, 96);
    gap(2'h1, 16'd20, 10'd0, 0, 160);
    slow = 1'b1;
    gap(2'h1, 16'd20, 10'd15, 0, 160);
    slow = 1'b0;
    gap(2'h1, 16'd0, 10'd15, 0, 120);
    gap(2'h0, 16'd0, 10'd0, 0, 960);
    gap(2'h0, 16'd21, 10'd0, 0, 1680);
    gap(2'h2, 16'd3, 10'd0, 0, 10);
    gap(2'h1, 16'd20, 10'd0, 1, 1);
    gap(2'h1, 16'd20, 10'd0, 2, 1);
    gap_throttle_reg_i = 16'h0;
    end_of_test;
  end
endmodule
